// [rtl/level_context_interrupt_mailbox.sv]
// Purpose: banked register file, level switching, host doorbells and mailbox
// Assumes: inputs synchronous to mclk; microcode drives register file ports
// Notes: level 16 uses its own register set besides the sixteen standard
`timescale 1ns/1ps
`default_nettype none
module level_context_interrupt_mailbox #(
  parameter int DW = lvl_ctx_pkg::DATA_W,
  parameter int MAW = lvl_ctx_pkg::MBOX_AW
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // microcode side of the register file
  input  wire logic [3:0]                    rf_addr,
  input  wire logic                          rf_we,
  input  wire logic [DW-1:0]                 rf_wdata,
  output logic [DW-1:0]                      rf_rdata,
  output logic                               rf_is_scratch,
  output logic [4:0]                         cur_level,
  // sequencer
  input  wire logic                          seq_step,
  input  wire logic                          seq_jump,
  input  wire logic [lvl_ctx_pkg::CSA_W-1:0] seq_jump_addr,
  input  wire logic                          level_exit,
  input  wire logic [15:0]                   int_level_req,
  output logic [lvl_ctx_pkg::CSA_W-1:0]      csa,
  output logic                               level_switch,
  // external sources
  input  wire logic                          host_doorbell,
  input  wire logic                          serial_irq,
  input  wire logic [3:0]                    serial_level,
  input  wire logic                          console_irq,
  input  wire logic [3:0]                    console_level,
  // host channel select and irq5
  input  wire logic [1:0]                    host_chan,
  output logic [3:0]                         chan_active,
  input  wire logic                          dev_doorbell,
  input  wire logic                          host_irq_ack,
  output logic                               host_irq5,
  // mailbox port, device side
  input  wire logic                          mb_dev_we,
  input  wire logic [MAW-1:0]                mb_dev_addr,
  input  wire logic [DW-1:0]                 mb_dev_wdata,
  output logic [DW-1:0]                      mb_dev_rdata,
  // mailbox port, host side
  input  wire logic                          mb_host_we,
  input  wire logic [MAW-1:0]                mb_host_addr,
  input  wire logic [DW-1:0]                 mb_host_wdata,
  output logic [DW-1:0]                      mb_host_rdata
);
  localparam int NSETS = lvl_ctx_pkg::NUM_LEVELS + 1;

  // sixteen sets plus the host level set
  logic [DW-1:0] rf_mem [NSETS*lvl_ctx_pkg::REGS_PER_SET]; // see [RQ1] [RQ3] [RQ4]
  logic [DW-1:0] mbox_mem [2**MAW]; // see [RQ11]

  lvl_ctx_pkg::seq_state_t st_ff, nxt_st;
  logic [4:0]  level_ff, nxt_level;
  logic [4:0]  ret_ff [NSETS];
  logic [4:0]  nxt_ret;
  logic [16:0] pend_ff, nxt_pend;
  logic [lvl_ctx_pkg::CSA_W-1:0] csa_ff, nxt_csa;
  logic        irq5_ff, nxt_irq5;
  logic [DW-1:0] rf_rdata_ff, mb_dev_rdata_ff, mb_host_rdata_ff;
  logic        hit;
  logic [4:0]  hit_level;
  logic [4:0]  tgt_ff, nxt_tgt;
  logic [16:0] set_mask;
  logic [16:0] clr_mask;
  logic        rf_wr_en;

  function automatic logic [8:0] rf_index(input logic [4:0] lvl, input logic [3:0] a);
    rf_index = {lvl, a}; // see [RQ5]
  endfunction : rf_index

  function automatic logic [15:0] onehot16(input logic [3:0] l);
    onehot16 = 16'h0001 << l;
  endfunction : onehot16

  level_prio_enc level_prio_enc_inst (
    .pend      (pend_ff),
    .cur_level (level_ff),
    .hit       (hit),
    .hit_level (hit_level)
  );

  // request collection; a new request beats its own clear
  always_comb begin
    set_mask = {1'b0, int_level_req}; // see [RQ8]
    if (serial_irq) begin
      set_mask[15:0] = set_mask[15:0] | onehot16(serial_level);
    end
    if (console_irq) begin
      set_mask[15:0] = set_mask[15:0] | onehot16(console_level);
    end
    set_mask[lvl_ctx_pkg::HOST_LEVEL] = host_doorbell; // see [RQ9]
    clr_mask = 17'h00000;
    if (st_ff == lvl_ctx_pkg::ST_ENTER) begin
      clr_mask[tgt_ff] = 1'b1;
    end
    nxt_pend = (pend_ff & ~clr_mask) | set_mask;
  end

  // level and sequencer machine
  // run: take a higher pending level, else leave, jump or step
  // save: one wait cycle; the register file takes no writes outside run
  // enter and leave: swap the working set, restart at the vector
  always_comb begin
    nxt_st       = st_ff;
    nxt_level    = level_ff;
    nxt_tgt      = tgt_ff;
    nxt_ret      = ret_ff[level_ff];
    nxt_csa      = csa_ff;
    level_switch = 1'b0;
    case (st_ff)
      lvl_ctx_pkg::ST_RUN: begin
        if (hit) begin // see [RQ7] [RQ16]
          nxt_tgt = hit_level;
          nxt_st  = lvl_ctx_pkg::ST_SAVE;
        end else if (level_exit && level_ff != 5'h00) begin
          nxt_st = lvl_ctx_pkg::ST_LEAVE;
        end else if (seq_jump) begin
          nxt_csa = seq_jump_addr;
        end else if (seq_step) begin
          nxt_csa = csa_ff + 13'h0001;
        end
      end
      lvl_ctx_pkg::ST_SAVE: begin
        nxt_st = lvl_ctx_pkg::ST_ENTER;
      end
      lvl_ctx_pkg::ST_ENTER: begin
        nxt_ret      = level_ff;
        nxt_level    = tgt_ff; // see [RQ6]
        nxt_csa      = lvl_ctx_pkg::CSA_INT_VEC;
        level_switch = 1'b1;
        nxt_st       = lvl_ctx_pkg::ST_RUN;
      end
      lvl_ctx_pkg::ST_LEAVE: begin
        nxt_level    = ret_ff[level_ff]; // see [RQ6]
        nxt_csa      = lvl_ctx_pkg::CSA_INT_VEC;
        level_switch = 1'b1;
        nxt_st       = lvl_ctx_pkg::ST_RUN;
      end
      default: begin
        nxt_st = lvl_ctx_pkg::ST_RUN;
      end
    endcase
  end

  // irq5 held until host acknowledges; a new doorbell wins
  always_comb begin
    nxt_irq5 = irq5_ff;
    if (host_irq_ack) begin
      nxt_irq5 = 1'b0;
    end
    if (dev_doorbell) begin
      nxt_irq5 = 1'b1; // see [RQ10] [RQ13]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq5_ff <= 1'b0;
    end else begin
      irq5_ff <= nxt_irq5;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff    <= lvl_ctx_pkg::ST_RUN;
      level_ff <= 5'h00;
      tgt_ff   <= 5'h00;
      pend_ff  <= 17'h00000;
      csa_ff   <= lvl_ctx_pkg::CSA_RESET;
      for (int i = 0; i < NSETS; i++) begin
        ret_ff[i] <= 5'h00;
      end
    end else begin
      st_ff    <= nxt_st;
      level_ff <= nxt_level;
      tgt_ff   <= nxt_tgt;
      pend_ff  <= nxt_pend;
      csa_ff   <= nxt_csa;
      if (st_ff == lvl_ctx_pkg::ST_ENTER) begin
        ret_ff[tgt_ff] <= nxt_ret;
      end
    end
  end

  // register file: no reset, synchronous read
  always_ff @(posedge mclk) begin
    if (rf_wr_en) begin
      rf_mem[rf_index(level_ff, rf_addr)] <= rf_wdata; // see [RQ5]
    end
    rf_rdata_ff <= rf_mem[rf_index(level_ff, rf_addr)];
  end

  // mailbox: no reset; the device port wins a same-cycle write
  always_ff @(posedge mclk) begin
    if (mb_dev_we) begin
      mbox_mem[mb_dev_addr] <= mb_dev_wdata; // see [RQ11] [RQ13]
    end else if (mb_host_we) begin
      mbox_mem[mb_host_addr] <= mb_host_wdata; // see [RQ11]
    end
    mb_dev_rdata_ff  <= mbox_mem[mb_dev_addr];
    mb_host_rdata_ff <= mbox_mem[mb_host_addr];
  end

  always_comb begin
    chan_active = 4'h0;
    chan_active[host_chan] = 1'b1; // see [RQ14]
  end

  assign rf_wr_en      = rf_we && (st_ff == lvl_ctx_pkg::ST_RUN); // see [RQ5]
  assign rf_rdata      = rf_rdata_ff;
  assign rf_is_scratch = (rf_addr >= 4'(lvl_ctx_pkg::CTX_REGS)); // see [RQ3] [RQ4]
  assign cur_level     = level_ff;
  assign csa           = csa_ff;
  assign host_irq5     = irq5_ff;
  assign mb_dev_rdata  = mb_dev_rdata_ff;
  assign mb_host_rdata = mb_host_rdata_ff;
endmodule : level_context_interrupt_mailbox
`default_nettype wire

// [pkg/lvl_ctx_pkg.sv]
// Purpose: constants for the level context and interrupt block
// Assumes: one clock mclk at 20 MHz, asynchronous active-high reset rst
// Notes: rules carried by the block, one to a line
// Function
// [RQ1] register file holds sixteen independent sets
// [RQ2] levels 0 to 15, 15 highest
// [RQ3] eight context registers: seven address, one status
// [RQ4] other eight registers are microprogram scratch
// [RQ5] only current level's set is used
// [RQ6] level change selects new working set
// [RQ7] sequencer steps addresses, honours pending conditions
// [RQ8] accept host, serial, console and internal requests
// [RQ9] host requests serviced on level 16
// [RQ10] device signals host on irq5 line
// [RQ11] both sides access shared mailbox memory
// [RQ12] host writes mailbox before interrupting device
// [RQ13] device writes mailbox, then interrupts host
// [RQ14] four channels: mailbox, console in, out, calendar
// [RQ15] host tests itself before device self-test
// [RQ16] switch only to strictly higher pending level
`default_nettype none
package lvl_ctx_pkg;
  localparam int NUM_LEVELS    = 16;
  localparam int REGS_PER_SET  = 16;
  localparam int CTX_REGS      = 8;
  localparam int ADDR_GEN_REGS = 7;
  localparam int STATUS_REG    = 7;
  localparam int DATA_W        = 16;
  localparam int LVL_W         = 5;
  localparam logic [4:0] HOST_LEVEL = 5'h10;
  localparam int MBOX_AW       = 8;
  localparam int CSA_W         = 13;
  localparam logic [12:0] CSA_RESET   = 13'h0000;
  localparam logic [12:0] CSA_INT_VEC = 13'h0100;

  typedef enum logic [1:0] {
    CH_MAILBOX  = 2'b00,
    CH_CONS_IN  = 2'b01,
    CH_CONS_OUT = 2'b10,
    CH_CALENDAR = 2'b11
  } host_chan_t;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_SAVE    = 2'b01,
    ST_ENTER   = 2'b10,
    ST_LEAVE   = 2'b11
  } seq_state_t;
endpackage : lvl_ctx_pkg
`default_nettype wire

// [rtl/level_prio_enc.sv]
// Purpose: picks highest pending level above the current one
// Assumes: level 16 is the host level
// Notes: pure combinational
`timescale 1ns/1ps
`default_nettype none
module level_prio_enc (
  input  wire logic [16:0] pend,
  input  wire logic [4:0]  cur_level,
  output logic             hit,
  output logic [4:0]       hit_level
);
  always_comb begin
    hit       = 1'b0;
    hit_level = 5'h00;
    for (int i = 0; i < 17; i++) begin
      if (pend[i] && (5'(i) > cur_level)) begin // see [RQ2] [RQ16]
        hit       = 1'b1;
        hit_level = 5'(i);
      end
    end
  end
endmodule : level_prio_enc
`default_nettype wire

// [verification/lvl_ctx_props.sv]
// Purpose: port checks of level switching, doorbells and channels
// Assumes: one clock mclk, rst active high
// Notes: bound into the top module
`timescale 1ns/1ps
`default_nettype none
module lvl_ctx_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [3:0]  rf_addr,
  input wire logic        rf_is_scratch,
  input wire logic [4:0]  cur_level,
  input wire logic [12:0] csa,
  input wire logic        level_switch,
  input wire logic        host_doorbell,
  input wire logic [1:0]  host_chan,
  input wire logic [3:0]  chan_active,
  input wire logic        dev_doorbell,
  input wire logic        host_irq_ack,
  input wire logic        host_irq5
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_SCRATCH: assert property (rf_is_scratch == rf_addr[3])
    else $error("scratch flag wrong");
  AST_RANGE: assert property (cur_level <= 5'h10)
    else $error("level out of range");
  AST_HOST_LVL: assert property (host_doorbell && cur_level < 5'h10 && !level_switch
    |-> ##[1:6] cur_level == 5'h10) else $error("host request not on level 16");
  AST_ENTRY_VEC: assert property ($changed(cur_level) && cur_level > $past(cur_level)
    |-> csa == 13'h0100) else $error("entry address wrong");
  AST_ONE_SET: assert property ($changed(cur_level) |-> $past(level_switch))
    else $error("level changed without switch");
  AST_IRQ_SET: assert property (dev_doorbell |=> host_irq5)
    else $error("irq5 not raised");
  AST_IRQ_CLR: assert property (host_irq_ack && !dev_doorbell |=> !host_irq5)
    else $error("irq5 not cleared");
  AST_IRQ_HOLD: assert property (!dev_doorbell && !host_irq_ack |=> $stable(host_irq5))
    else $error("irq5 moved on its own");
  AST_CHAN: assert property (chan_active == (4'h1 << host_chan))
    else $error("channel select wrong");
  cover property (level_switch);
  cover property (cur_level == 5'h10);
  cover property ($rose(host_irq5));
endmodule : lvl_ctx_props
bind level_context_interrupt_mailbox lvl_ctx_props lvl_ctx_props_inst (.mclk, .rst, .rf_addr,
  .rf_is_scratch, .cur_level, .csa, .level_switch, .host_doorbell, .host_chan, .chan_active,
  .dev_doorbell, .host_irq_ack, .host_irq5);
`default_nettype wire

// [verification/host_model.sv]
// Purpose: host side of the mailbox and doorbells
// Assumes: driven on mclk rising edges
// Notes: write data is inverted once released
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        mclk,
  input  wire logic [15:0] mb_host_rdata,
  output logic             host_doorbell,
  output logic             host_irq_ack,
  output logic             mb_host_we,
  output logic [7:0]       mb_host_addr,
  output logic [15:0]      mb_host_wdata
);
  initial begin
    {host_doorbell, host_irq_ack, mb_host_we} = 3'h0;
    mb_host_addr = 8'h00;
    mb_host_wdata = 16'h0000;
  end
  task post(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk) mb_host_we <= 1'b1;
    mb_host_addr <= a;
    mb_host_wdata <= d;
    @(posedge mclk) mb_host_we <= 1'b0;
    mb_host_wdata <= ~d;
    host_doorbell <= 1'b1;
    @(posedge mclk) host_doorbell <= 1'b0;
  endtask : post
  task fetch(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk) mb_host_addr <= a;
    @(posedge mclk);
    @(negedge mclk) d = mb_host_rdata;
    @(posedge mclk) host_irq_ack <= 1'b1;
    @(posedge mclk) host_irq_ack <= 1'b0;
  endtask : fetch
  // link check by the host before any device work: write, then read back
  task probe(input logic [7:0] a, input logic [15:0] v, output logic [15:0] d);
    @(posedge mclk) mb_host_we <= 1'b1;
    mb_host_addr <= a;
    mb_host_wdata <= v;
    @(posedge mclk) mb_host_we <= 1'b0;
    mb_host_wdata <= ~v;
    @(posedge mclk);
    @(negedge mclk) d = mb_host_rdata;
  endtask : probe
endmodule : host_model
`default_nettype wire

// [verification/level_context_interrupt_mailbox_tb.sv]
// Purpose: self-checking bench of the level and mailbox block
// Assumes: 20 MHz clock, reset 16 cycles
// Notes: inputs change by non-blocking assignment on rising edges
`timescale 1ns/1ps
`default_nettype none
module level_context_interrupt_mailbox_tb;
  logic        mclk, rst, rf_we, rf_is_scratch, seq_step, seq_jump, level_exit, level_switch;
  logic        host_doorbell, serial_irq, console_irq, dev_doorbell, host_irq_ack, host_irq5;
  logic        mb_dev_we, mb_host_we;
  logic [1:0]  host_chan;
  logic [3:0]  rf_addr, serial_level, console_level, chan_active;
  logic [4:0]  cur_level;
  logic [7:0]  mb_dev_addr, mb_host_addr;
  logic [12:0] seq_jump_addr, csa;
  logic [15:0] rf_wdata, rf_rdata, int_level_req, mb_dev_wdata, mb_dev_rdata;
  logic [15:0] mb_host_wdata, mb_host_rdata, d;
  int          n_fail, n_compared, i;
  level_context_interrupt_mailbox level_context_interrupt_mailbox_inst (.mclk, .rst, .rf_addr,
    .rf_we, .rf_wdata, .rf_rdata, .rf_is_scratch, .cur_level, .seq_step, .seq_jump,
    .seq_jump_addr, .level_exit, .int_level_req, .csa, .level_switch, .host_doorbell,
    .serial_irq, .serial_level, .console_irq, .console_level, .host_chan, .chan_active,
    .dev_doorbell, .host_irq_ack, .host_irq5, .mb_dev_we, .mb_dev_addr, .mb_dev_wdata,
    .mb_dev_rdata, .mb_host_we, .mb_host_addr, .mb_host_wdata, .mb_host_rdata);
  host_model host_model_inst (.mclk, .mb_host_rdata, .host_doorbell, .host_irq_ack,
    .mb_host_we, .mb_host_addr, .mb_host_wdata);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wait_lvl(input logic [4:0] exp);
    for (int k = 0; k < 12 && cur_level !== exp; k++) @(negedge mclk);
    chk({11'h000, cur_level}, {11'h000, exp});
    if (cur_level !== exp) results();
  endtask : wait_lvl
  task rd(input logic [3:0] a);
    @(posedge mclk) rf_addr <= a;
    @(posedge mclk);
    @(negedge mclk) d = rf_rdata;
  endtask : rd
  task leave;
    @(posedge mclk) level_exit <= 1'b1;
    @(posedge mclk) level_exit <= 1'b0;
  endtask : leave
  task t_link;
    host_model_inst.probe(8'hF0, 16'hC3C3, d);
    chk(d, 16'hC3C3);
    $display("host link check done");
    if (d !== 16'hC3C3) results();
  endtask : t_link
  task t_regs;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk) rf_we <= 1'b1;
      rf_addr <= i[3:0];
      rf_wdata <= 16'hA500 + 16'(i);
    end
    @(posedge mclk) rf_we <= 1'b0;
    for (i = 0; i < 16; i++) begin
      rd(i[3:0]);
      chk(d, 16'hA500 + 16'(i));
      chk({15'h0000, rf_is_scratch}, {15'h0000, i[3]});
    end
    $display("regs done");
  endtask : t_regs
  task t_host;
    host_model_inst.post(8'h10, 16'h1234);
    for (i = 0; i < 12 && level_switch !== 1'b1; i++) @(negedge mclk);
    chk(16'(i), 16'h0003);
    chk({15'h0000, level_switch}, 16'h0001);
    wait_lvl(5'h10);
    chk({3'h0, csa}, 16'h0100);
    @(posedge mclk) rf_we <= 1'b1;
    rf_addr <= 4'h0;
    rf_wdata <= 16'hBEEF;
    mb_dev_addr <= 8'h10;
    @(posedge mclk) rf_we <= 1'b0;
    @(negedge mclk) chk(mb_dev_rdata, 16'h1234);
    rd(4'h0);
    chk(d, 16'hBEEF);
    leave();
    wait_lvl(5'h00);
    rd(4'h0);
    chk(d, 16'hA500);
    $display("host done");
  endtask : t_host
  task t_prio;
    @(posedge mclk) int_level_req <= 16'h0020;
    @(posedge mclk) int_level_req <= 16'h0000;
    wait_lvl(5'h05);
    @(posedge mclk) serial_irq <= 1'b1;
    serial_level <= 4'h3;
    @(posedge mclk) serial_irq <= 1'b0;
    repeat (5) @(negedge mclk);
    chk({11'h000, cur_level}, 16'h0005);
    @(posedge mclk) console_irq <= 1'b1;
    console_level <= 4'h9;
    @(posedge mclk) console_irq <= 1'b0;
    wait_lvl(5'h09);
    leave();
    wait_lvl(5'h05);
    leave();
    wait_lvl(5'h03);
    leave();
    wait_lvl(5'h00);
    $display("prio done");
  endtask : t_prio
  task t_dev;
    @(posedge mclk) mb_dev_we <= 1'b1;
    mb_dev_addr <= 8'h20;
    mb_dev_wdata <= 16'h5A5A;
    @(posedge mclk) mb_dev_we <= 1'b0;
    dev_doorbell <= 1'b1;
    @(posedge mclk) dev_doorbell <= 1'b0;
    @(negedge mclk) chk({15'h0000, host_irq5}, 16'h0001);
    host_model_inst.fetch(8'h20, d);
    chk(d, 16'h5A5A);
    @(negedge mclk) chk({15'h0000, host_irq5}, 16'h0000);
    $display("device doorbell done");
  endtask : t_dev
  task t_misc;
    @(posedge mclk) seq_jump <= 1'b1;
    seq_jump_addr <= 13'h0ABC;
    @(posedge mclk) seq_jump <= 1'b0;
    seq_step <= 1'b1;
    @(negedge mclk) chk({3'h0, csa}, 16'h0ABC);
    @(posedge mclk) seq_step <= 1'b0;
    @(negedge mclk) chk({3'h0, csa}, 16'h0ABD);
    for (i = 0; i < 4; i++) begin
      @(posedge mclk) host_chan <= i[1:0];
      @(negedge mclk) chk({12'h000, chan_active}, 16'h0001 << i);
    end
    $display("sequencer and channels done");
  endtask : t_misc
  initial begin
    rst = 1'b1;
    {rf_we, seq_step, seq_jump, level_exit, serial_irq, console_irq} = 6'h00;
    {dev_doorbell, mb_dev_we, host_chan, rf_addr, serial_level, console_level} = 16'h0000;
    {mb_dev_addr, seq_jump_addr, rf_wdata, int_level_req, mb_dev_wdata} = 69'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_link();
    t_regs();
    t_host();
    t_prio();
    t_dev();
    t_misc();
    results();
  end
endmodule : level_context_interrupt_mailbox_tb
`default_nettype wire
